// ### rtl/reset_source_combiner.sv
// Purpose: combine reset sources into the master reset and log causes
// Assumes: clk keeps running while sources are active; rst_n is power-on
// Notes:   por input asserts the power-on source synchronously
//          master reset is registered, so it trails its source by one edge
//          a short source pulse still gives a full cycle of master reset
//          hardware events beat a software write landing in the same cycle
//          power-on overrides every write for as long as it is held
//          sleep or idle entry retires an old timeout flag
//          a timeout in that same cycle keeps its flag
//          status word at the second address mirrors the master reset line
//          unimplemented bits are absent, so they can never hold a one
//          bits eight and five also drive outputs; none of the flags feeds the reset line
//          flags clear to zero while rst_n is low; hold power-on to set bits one and zero
// Function
// R1: any active source asserts master reset
// R2: undefined-state registers keep value except power-on
// R3: each reset kind sets its own flag
// R4: power-on clears all but bits one, zero
// R5: software writes bits; writing never resets
// R6: software should clear flags after reading
// R7: bit 15 flags trap conflict reset
// R8: bit 14 flags bad opcode or pointer
// R9: bits 13 to 10 read zero
// R10: bit 9 flags configuration mismatch reset
// R11: bit 8 keeps progmem bias in sleep
// R12: bit 7 flags external pin reset
// R13: bit 6 flags reset instruction
// R14: bit 5 watchdog enable, config forces on
// R15: bit 4 flags watchdog timeout
// R16: bit 3 shows device was asleep
// R17: bit 2 shows device was idle
// R18: bit 1 set by brown-out and power-on
// R19: bit 0 set by power-on
// R20: flags captured during reset, kept otherwise
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module reset_source_combiner
	import rsc_pkg::*;
(
	// clock and power-domain reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,

	// reset sources, active high except the pin
	input  wire logic                   powerOnReset,
	input  wire logic                   brownoutReset,
	input  wire logic                   externalClearPin_n,
	input  wire logic                   softResetReq,
	input  wire logic                   watchdogTimeout,
	input  wire logic                   configMismatch,
	input  wire logic                   trapConflict,
	input  wire logic                   illegalOpcode,
	input  wire logic                   uninitPointerReset,

	// power-save entry and watchdog configuration
	input  wire logic                   enterSleep,
	input  wire logic                   enterIdle,
	input  wire logic                   watchdogConfigEnable,

	// register port
	input  wire logic [`RSC_ADDR_W-1:0] regAddr,
	input  wire logic [15:0]            regWriteData,
	input  wire logic                   regWrite,
	input  wire logic                   regRead,

	// results
	output logic      [15:0]            regReadData,
	output logic                        masterSystemReset,
	output logic                        watchdogEnable,
	output logic                        progmemSleepPower
);
	logic [`RSC_NSRC-1:0] srcActive;
	logic [15:0]          causeReg;
	logic [15:0]          hwSet;
	logic [15:0]          hwClear;
	logic                 porActive;
	logic                 swWrite;
	logic [15:0]          next_readData;
	logic                 anySource;
	logic                 extPinActive;
	logic                 badOpActive;
	logic [15:0]          faultSet;
	logic [15:0]          causeSet;
	logic [15:0]          saveSet;
	logic [15:0]          saveClear;
	logic [15:0]          writeEnable;
	logic [15:0]          causeRead;
	logic [15:0]          statusWord;
	logic                 selCause;
	logic                 selStatus;

	// fixed masks as typed constants so bit selects stay one bit wide
	localparam logic [15:0] IMPL_MASK = `RSC_IMPL_MASK;
	localparam logic [15:0] POR_VALUE = `RSC_POR_VALUE;

	// reset sequencer states, binary coded
	typedef enum logic [1:0] {
		RSC_ST_POWERUP = 2'b00,
		RSC_ST_RUN     = 2'b01,
		RSC_ST_HOLD    = 2'b10
	} rsc_rst_state_type;

	rsc_rst_state_type    resetState;
	rsc_rst_state_type    next_resetState;

	// pin is active low; fold to active high once here
	assign extPinActive = !externalClearPin_n;
	// R8: any of the decoder faults
	assign badOpActive  = illegalOpcode || uninitPointerReset;

	// source vector in package index order
	always_comb begin
		srcActive                  = '0;
		srcActive[RSC_SRC_POWERON] = powerOnReset;
		srcActive[RSC_SRC_BROWN]   = brownoutReset;
		srcActive[RSC_SRC_EXTPIN]  = extPinActive;
		srcActive[RSC_SRC_SOFT]    = softResetReq;
		srcActive[RSC_SRC_WATCHDOG_TIMEOUT_FLAG]    = watchdogTimeout;
		srcActive[RSC_SRC_CFGMIS]  = configMismatch;
		srcActive[RSC_SRC_TRAP]    = trapConflict;
		srcActive[RSC_SRC_BADOP]   = illegalOpcode;
		srcActive[RSC_SRC_UNINIT]  = uninitPointerReset;
	end

	// R1: any active source counts
	assign anySource = |srcActive;

	// R1: sequencer holds while a source stands
	// no release stretch: line drops one edge after the last source
	always_comb begin
		next_resetState = resetState;
		case (resetState)
			RSC_ST_POWERUP: begin
				if (anySource) begin
					next_resetState = RSC_ST_HOLD;
				end else begin
					next_resetState = RSC_ST_RUN;
				end
			end
			RSC_ST_RUN: begin
				if (anySource) begin
					next_resetState = RSC_ST_HOLD;
				end
			end
			RSC_ST_HOLD: begin
				if (!anySource) begin
					next_resetState = RSC_ST_RUN;
				end
			end
			default: begin
				next_resetState = RSC_ST_HOLD;
			end
		endcase
	end

	// sequencer state; power-up is left on the first edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resetState <= RSC_ST_POWERUP;
		end else begin
			resetState <= next_resetState;
		end
	end

	// R1: combined master reset
	// registered so the reset line never glitches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			masterSystemReset <= 1'b1;
		end else begin
			masterSystemReset <= (next_resetState == RSC_ST_HOLD);
		end
	end

	// power-on source drives the override path
	assign porActive = powerOnReset;
	// R5: a software write only stores; no path feeds srcActive
	assign swWrite   = regWrite && selCause;
	// per-bit write enable; unimplemented bits never take a write
	assign writeEnable = swWrite ? IMPL_MASK : `RSC_ZERO16;

	// R3: R20: fault causes set their own flag while active
	// level sources simply set again each cycle they stand
	always_comb begin
		faultSet = `RSC_ZERO16;
		// R7: trap conflict
		faultSet[`RSC_BIT_TRAP]   = trapConflict;
		// R8: opcode or uninit pointer
		faultSet[`RSC_BIT_BADOP]  = badOpActive;
		// R10: configuration mismatch
		faultSet[`RSC_BIT_CFGMIS] = configMismatch;
	end

	// R3: R20: pin, instruction, timer and supply causes
	// both uninit and opcode faults share one flag by design
	always_comb begin
		causeSet = faultSet;
		// R12: external pin held low
		causeSet[`RSC_BIT_EXTPIN] = extPinActive;
		// R13: reset instruction
		causeSet[`RSC_BIT_SOFT]   = softResetReq;
		// R15: watchdog timeout
		causeSet[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG]   = watchdogTimeout;
		// R18: brown-out
		causeSet[`RSC_BIT_BROWN]  = brownoutReset;
	end

	// power-save entry marks and timeout clear
	always_comb begin
		saveSet   = `RSC_ZERO16;
		saveClear = `RSC_ZERO16;
		// R16: sleep entry
		saveSet[`RSC_BIT_SLEEP]  = enterSleep;
		// R17: idle entry
		saveSet[`RSC_BIT_IDLE]   = enterIdle;
		// a new timeout in the same cycle wins over this clear
		saveClear[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = enterSleep || enterIdle;
	end

	// merge; power-on overrides everything else
	// clear loads the power-on value, so one path serves both
	always_comb begin
		hwSet   = causeSet | saveSet;
		hwClear = saveClear;
		// R18: R19: power-on sets bits one and zero
		hwSet[`RSC_BIT_BROWN]   = hwSet[`RSC_BIT_BROWN] || porActive;
		hwSet[`RSC_BIT_POWERON] = porActive;
		// R4: power-on clears every flag outside bits one and zero
		if (porActive) begin
			hwSet   = POR_VALUE;
			hwClear = ~POR_VALUE;
		end
	end

	// R2: R20: flags only change on events, writes or power-on
	// R9: unimplemented bits are never instantiated
	// a flag is one bit cell; set outranks clear, clear outranks write
	// so a cause arriving during a software clear is not lost
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : gen_flag
			if (IMPL_MASK[i]) begin : gen_impl
				logic flagOut;
				rsc_flag_bit u_bit (
					.clk      (clk),
					.rst_n    (rst_n),
					.porValue (POR_VALUE[i]),
					.hwSet    (hwSet[i]),
					.hwClear  (hwClear[i]),
					.swWrite  (writeEnable[i]),
					.swData   (regWriteData[i]),
					.flag     (flagOut)
				);
				assign causeReg[i] = flagOut;
			end else begin : gen_unimpl
				assign causeReg[i] = 1'b0;
			end
		end
	endgenerate

	// R11: program memory bias kept in sleep when set
	// follows the stored bit; the sleep controller samples it
	always_comb begin
		progmemSleepPower = causeReg[`RSC_BIT_PMSLEEP];
	end

	// R14: config bit at one forces the watchdog on
	// software cannot switch off a watchdog fixed on by configuration
	always_comb begin
		watchdogEnable = watchdogConfigEnable || causeReg[`RSC_BIT_WDTEN];
	end

	// address decode for the two words
	assign selCause  = (regAddr == `RSC_ADDR_CAUSE);
	assign selStatus = (regAddr == `RSC_ADDR_STATUS);
	// status word: live master reset in bit zero
	assign statusWord = {15'h0000, masterSystemReset};
	// unimplemented bits masked again on the read side
	assign causeRead = causeReg & IMPL_MASK;

	// read mux, unmapped addresses answer zero
	always_comb begin
		if (selCause) begin
			next_readData = causeRead;
		end else if (selStatus) begin
			next_readData = statusWord;
		end else begin
			next_readData = `RSC_ZERO16;
		end
	end

	// read data valid the cycle after the strobe only
	// cleared between reads so a stale word never looks like data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regReadData <= `RSC_ZERO16;
		end else if (regRead) begin
			regReadData <= next_readData;
		end else begin
			regReadData <= `RSC_ZERO16;
		end
	end
endmodule : reset_source_combiner

// ### rtl/rsc_cfg.svh
// Purpose: constants for the reset source combiner and cause register
// Assumes: 16-bit cause register at a single word address
// Notes:   bit positions, reset value and address map
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_ADDR_W        4
`define RSC_ADDR_CAUSE    4'h0
`define RSC_ADDR_STATUS   4'h1
`define RSC_BIT_TRAP      15
`define RSC_BIT_BADOP     14
`define RSC_BIT_CFGMIS    9
`define RSC_BIT_PMSLEEP   8
`define RSC_BIT_EXTPIN    7
`define RSC_BIT_SOFT      6
`define RSC_BIT_WDTEN     5
`define RSC_BIT_WATCHDOG_TIMEOUT_FLAG      4
`define RSC_BIT_SLEEP     3
`define RSC_BIT_IDLE      2
`define RSC_BIT_BROWN     1
`define RSC_BIT_POWERON   0
`define RSC_IMPL_MASK     16'hC3FF
`define RSC_POR_VALUE     16'h0003
`define RSC_ZERO16        16'h0000
`define RSC_NSRC          9

`endif

// ### rtl/rsc_pkg.sv
// Purpose: types for the reset source combiner
// Assumes: sources are indexed in a fixed order
// Notes:   source index order matches the srcActive vector
package rsc_pkg;
	typedef enum logic [3:0] {
		RSC_SRC_POWERON = 4'h0,
		RSC_SRC_BROWN   = 4'h1,
		RSC_SRC_EXTPIN  = 4'h2,
		RSC_SRC_SOFT    = 4'h3,
		RSC_SRC_WATCHDOG_TIMEOUT_FLAG    = 4'h4,
		RSC_SRC_CFGMIS  = 4'h5,
		RSC_SRC_TRAP    = 4'h6,
		RSC_SRC_BADOP   = 4'h7,
		RSC_SRC_UNINIT  = 4'h8
	} rsc_src_type;
endpackage : rsc_pkg

// ### rtl/rsc_flag_bit.sv
// Purpose: one sticky cause flag with software write
// Assumes: hardware set and software write arrive synchronous to clk
// Notes:   hardware set wins over a software write in the same cycle;
//          a hardware clear loads the bit's power-on value
`timescale 1ns/1ps
module rsc_flag_bit
	import rsc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic porValue,
	input  wire logic hwSet,
	input  wire logic hwClear,
	input  wire logic swWrite,
	input  wire logic swData,
	output logic      flag
);
	// set beats clear so an event in the clearing cycle is not lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else if (hwSet) begin
			flag <= 1'b1;
		end else if (hwClear) begin
			flag <= porValue;
		end else if (swWrite) begin
			flag <= swData;
		end
	end
endmodule : rsc_flag_bit

// ### bench/rsc_props.sv
// Purpose: port assertions for the reset source combiner
// Assumes: one clock, rst_n async low
// Notes:   cause flags are seen through register reads, bit 8 also at progmemSleepPower
`timescale 1ns/1ps
module rsc_props
	import rsc_pkg::*;
(
	input wire logic        clk, rst_n, powerOnReset, brownoutReset, externalClearPin_n,
	input wire logic        softResetReq, watchdogTimeout, configMismatch, trapConflict,
	input wire logic        illegalOpcode, uninitPointerReset, enterSleep, enterIdle,
	input wire logic        watchdogConfigEnable, regWrite, regRead, masterSystemReset,
	input wire logic        watchdogEnable, progmemSleepPower,
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWriteData, regReadData
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// sources other than power-on, and a cause read
	wire logic otherSrc = brownoutReset | ~externalClearPin_n | softResetReq | watchdogTimeout
		| configMismatch | trapConflict | illegalOpcode | uninitPointerReset;
	wire logic anySrc = otherSrc | powerOnReset;
	wire logic rdCause = regRead & (regAddr == 4'h0);
	chk_src_reset: assert property (anySrc |=> masterSystemReset)
		else $error("master reset missed a source");
	chk_quiet_release: assert property (!anySrc |=> !masterSystemReset)
		else $error("master reset without a source");
	chk_unimpl_zero: assert property (regRead |=> regReadData[13:10] == 4'h0)
		else $error("unimplemented bits read nonzero");
	chk_idle_bus: assert property (!regRead |=> regReadData == 16'h0000)
		else $error("read data outside its cycle");
	chk_wdt_forced: assert property (watchdogConfigEnable |-> watchdogEnable)
		else $error("watchdog not forced on");
	chk_por_value: assert property (powerOnReset && !otherSrc && !enterSleep
		&& !enterIdle ##1 !anySrc && !enterSleep && !enterIdle && !regWrite
		##1 rdCause |=> regReadData == 16'h0003)
		else $error("power-on value wrong");
	chk_trap_flag: assert property (trapConflict && !powerOnReset
		##1 !regWrite && !powerOnReset ##1 rdCause |=> regReadData[15])
		else $error("trap flag missing");
	chk_pin_flag: assert property (!externalClearPin_n && !powerOnReset
		##1 !regWrite && !powerOnReset ##1 rdCause |=> regReadData[7])
		else $error("pin flag missing");
	chk_pm_sleep: assert property (regWrite && regAddr == 4'h0 && !powerOnReset
		|=> progmemSleepPower == $past(regWriteData[8]))
		else $error("sleep power bit not written");
endmodule : rsc_props
bind reset_source_combiner rsc_props rsc_props_i (.*);

// ### bench/rsc_source_model.sv
// Purpose: reset sources and power-save requests around the combiner
// Assumes: index order of rsc_src_type, then sleep 9, idle 10
// Notes:   pulse gives a one-cycle event and hold an n-edge one, both launched after an edge
`timescale 1ns/1ps
module rsc_source_model
	import rsc_pkg::*;
(
	input  wire logic        clk,
	output logic      [10:0] src
);
	// quiet sources until a scenario fires one
	initial src = 11'h000;
	task automatic pulse(input int k);
		@(posedge clk);
		src[k] <= 1'b1;
		@(posedge clk);
		src[k] <= 1'b0;
	endtask : pulse
	// hold one source high for n edges
	task automatic hold(input int k, input int n);
		@(posedge clk);
		src[k] <= 1'b1;
		repeat (n) @(posedge clk);
		src[k] <= 1'b0;
	endtask : hold
endmodule : rsc_source_model

// ### bench/tb_top.sv
// Purpose: register-level tests of the reset source combiner
// Assumes: cause register at 0x0, status at 0x1
// Notes:   the source model fires each event once, then watchdog and sleep again
`timescale 1ns/1ps
module tb_top import rsc_pkg::*;;
	logic clk, rst_n, regWrite, regRead, watchdogConfigEnable;
	logic [3:0]  regAddr;
	logic [15:0] regWriteData;
	wire logic [15:0] regReadData;
	wire logic masterSystemReset, watchdogEnable, progmemSleepPower;
	wire logic [10:0] src;
	int errorCnt, cmpCount;
	logic [15:0] expTab [0:10] = '{16'h0003, 16'h0002, 16'h0080, 16'h0040, 16'h0010,
		16'h0200, 16'h8000, 16'h4000, 16'h4000, 16'h0008, 16'h0004};
	rsc_source_model rsc_source_model_i (.clk, .src);
	reset_source_combiner reset_source_combiner_i (.clk, .rst_n, .powerOnReset(src[0]),
		.brownoutReset(src[1]), .externalClearPin_n(~src[2]), .softResetReq(src[3]),
		.watchdogTimeout(src[4]), .configMismatch(src[5]), .trapConflict(src[6]),
		.illegalOpcode(src[7]), .uninitPointerReset(src[8]), .enterSleep(src[9]),
		.enterIdle(src[10]), .watchdogConfigEnable, .regAddr, .regWriteData, .regWrite,
		.regRead, .regReadData, .masterSystemReset, .watchdogEnable, .progmemSleepPower);
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errorCnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
		#1;
	endtask : wr
	// read data is looked at only in the cycle after the strobe
	task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 check("read data", regReadData, exp);
	endtask : rdc
	task automatic reportAndStop();
		$display("compares %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : reportAndStop
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// watchdog cut-off, far beyond the fewer than a hundred cycles needed
	initial begin
		repeat (5000) @(posedge clk);
		errorCnt++;
		reportAndStop();
	end
	initial begin
		{rst_n, regWrite, regRead, watchdogConfigEnable} = 4'h0;
		regAddr = 4'h0;
		regWriteData = 16'h0000;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// every event alone, flags cleared after each read
		for (int k = 0; k < 11; k++) begin
			rsc_source_model_i.pulse(k);
			#1 check("master reset", {15'h0, masterSystemReset}, {15'h0, k < 9});
			rdc(4'h0, expTab[k]);
			wr(4'h0, 16'h0000);
		end
		$display("test sources done");
		wr(4'h0, 16'hFFFF);
		check("reset by write", {15'h0, masterSystemReset}, 16'h0000);
		check("sleep power", {15'h0, progmemSleepPower}, 16'h0001);
		rdc(4'h0, 16'hC3FF);
		wr(4'h0, 16'h0000);
		check("watchdog off", {15'h0, watchdogEnable}, 16'h0000);
		@(posedge clk) watchdogConfigEnable <= 1'b1;
		#1 check("watchdog forced", {15'h0, watchdogEnable}, 16'h0001);
		rdc(4'h5, 16'h0000);
		fork
			rsc_source_model_i.hold(4, 3);
			begin
				@(posedge clk);
				rdc(4'h1, 16'h0001);
			end
		join
		$display("test register done");
		wr(4'h0, 16'h0010);
		rsc_source_model_i.pulse(9);
		rdc(4'h0, 16'h0008);
		$display("test sleep clears timeout done");
		reportAndStop();
	end
endmodule : tb_top
